/* File: rtl/rds_group_scheduler_irq.v */
// What this block does
// - PS group start raises interrupt when its enable bit is set.
// - Each circular buffer fetch raises interrupt when enabled.
// - Each group FIFO fetch raises interrupt when enabled.
// - Fetching the last circular buffer group raises wrap interrupt when enabled.
// - Fetching the last FIFO group raises empty interrupt when enabled.
// - Interrupt enables reset to zero; upper bits read zero.
// - Program identifier goes to block A and type B block C; resets 0x40A7.
// - Mix setting decides how often PS groups interleave with buffered groups.
// - Mix code zero sends PS only when the group buffer is empty.
// - Codes 1..6 give PS shares 12.5, 25, 50, 75, 87.5, 100 percent.
// - Mix field is three bits, resets to code 3, valid values 0..6.
// - Properties are accessed only in powered-up mode.
// - Clear-to-send is set once the next command may be issued.
`timescale 1ns/100ps
`include "rds_sched_consts.vh"

module rds_group_scheduler_irq #(
	parameter CTS_BUSY_CYCLES = (`CTS_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire                     clock_i,
	input  wire                     rst_i,
	// Avalon-MM slave, byte addressed
	input  wire [`ADDR_BITS-1:0]    address_i,
	input  wire                     read_i,
	input  wire                     write_i,
	input  wire [31:0]              writedata_i,
	input  wire [3:0]               byteenable_i,
	output wire [31:0]              readdata_o,
	output wire                     waitrequest_o,
	output wire                     irq_o,
	// Group slot and buffer state from the transmit path
	input  wire                     slot_tick_i,
	input  wire                     ring_avail_i,
	input  wire                     ring_last_i,
	input  wire                     queue_avail_i,
	input  wire                     queue_last_i,
	output wire                     ps_start_o,
	output wire                     ring_fetch_o,
	output wire                     queue_fetch_o,
	output wire [15:0]              block_a_ident_o,
	output wire [15:0]              block_c_ident_o,
	output wire                     cts_o
);

	// Busy time is cut to the counter width; keep the parameter below 256
	localparam [`CTS_CNT_W-1:0] CTS_LOAD   = CTS_BUSY_CYCLES[`CTS_CNT_W-1:0];
	localparam [`CTS_CNT_W-1:0] CTS_ONE    = {{(`CTS_CNT_W-1){1'b0}}, 1'b1};
	localparam [`PHASE_W-1:0]   PHASE_STEP = {{(`PHASE_W-1){1'b0}}, 1'b1};

	reg  [`EN_COUNT-1:0]        irq_enables;
	reg  [15:0]                 program_ident;
	reg  [`SHARE_W-1:0]         ps_share;
	reg  [1:0]                  control;
	reg  [`EV_COUNT-1:0]        status;
	reg                         ack;
	reg  [31:0]                 rdata;
	reg  [`CTS_CNT_W-1:0]       cts_cnt;
	reg                         cts;
	reg  [`PHASE_W-1:0]         phase;
	reg                         ps_start;
	reg                         ring_fetch;
	reg                         queue_fetch;
	reg  [`EV_COUNT-1:0]        next_status;
	reg  [31:0]                 next_rdata;
	reg  [3:0]                  ps_slots;
	reg                         pick_ps;
	reg                         ring_wrap;
	reg                         queue_empty;
	reg                         next_cts;
	reg  [`CTS_CNT_W-1:0]       next_cts_cnt;
	reg                         next_ack;

	wire [15:0]                 index    = address_i[`ADDR_BITS-1:`IDX_LSB];
	wire                        request  = read_i | write_i;
	wire                        accept   = request & ack;
	wire                        wr_ok    = write_i & accept;
	wire                        powered  = control[`CTL_POWERED_UP];
	wire                        is_prop  = (index == `IDX_IRQ_ENABLES) |
	                                       (index == `IDX_PROGRAM_IDENT) |
	                                       (index == `IDX_PS_RATIO);
	wire                        buf_any  = ring_avail_i | queue_avail_i;
	wire [`EV_COUNT-1:0]        events;

	// Decoded selects; property selects already fold in the power state
	wire                        sel_en   = powered & (index == `IDX_IRQ_ENABLES);
	wire                        sel_pi   = powered & (index == `IDX_PROGRAM_IDENT);
	wire                        sel_mix  = powered & (index == `IDX_PS_RATIO);
	wire                        sel_ctl  = (index == `IDX_CONTROL);
	wire                        sel_stat = (index == `IDX_EVENT_STATUS);
	wire                        rd_ok    = read_i & accept;

	// Read views, zero extended so reserved bits always read as zero
	wire [31:0]                 view_en   = {{(32-`EN_COUNT){1'b0}}, irq_enables};
	wire [31:0]                 view_pi   = {16'h0000, program_ident};
	wire [31:0]                 view_mix  = {{(32-`SHARE_W){1'b0}}, ps_share};
	wire [31:0]                 view_ctl  = {{(32-`CTL_W){1'b0}}, control};
	wire [31:0]                 view_stat = {{(32-`EV_COUNT){1'b0}}, status};

	// One wait state: the request is sampled, answered on the next edge
	assign waitrequest_o   = request & ~ack;
	assign readdata_o      = rdata;
	assign block_a_ident_o = program_ident;
	assign block_c_ident_o = program_ident;
	assign ps_start_o      = ps_start;
	assign ring_fetch_o    = ring_fetch;
	assign queue_fetch_o   = queue_fetch;
	assign cts_o           = cts;

	// Every access takes two cycles; a simpler decode traded for half the rate
	always @* begin
		next_ack = request & ~ack;
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= next_ack;
		end
	end

	// Read data is fixed in the wait cycle so it stands at the accepting edge
	always @* begin
		next_rdata = 32'h0000_0000;
		case (index)
			`IDX_IRQ_ENABLES: begin
				if (powered) begin
					next_rdata = view_en;
				end
			end
			`IDX_PROGRAM_IDENT: begin
				if (powered) begin
					next_rdata = view_pi;
				end
			end
			`IDX_PS_RATIO: begin
				if (powered) begin
					next_rdata = view_mix;
				end
			end
			`IDX_CONTROL: begin
				next_rdata = view_ctl;
			end
			`IDX_EVENT_STATUS: begin
				next_rdata = view_stat;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			rdata <= 32'h0000_0000;
		end else if (read_i & ~ack) begin
			rdata <= next_rdata;
		end
	end

	// Writes to properties outside powered-up mode are dropped
	always @(posedge clock_i) begin
		if (rst_i) begin
			irq_enables <= `RST_IRQ_ENABLES;
		end else if (wr_ok && sel_en && byteenable_i[0]) begin
			irq_enables <= writedata_i[`EN_COUNT-1:0];
		end
	end

	// Byte lanes honoured so a host can patch either half of the identifier
	always @(posedge clock_i) begin
		if (rst_i) begin
			program_ident <= `RST_PROGRAM_IDENT;
		end else if (wr_ok && sel_pi) begin
			if (byteenable_i[0]) begin
				program_ident[`BYTE0_MSB:`BYTE0_LSB] <= writedata_i[`BYTE0_MSB:`BYTE0_LSB];
			end
			if (byteenable_i[1]) begin
				program_ident[`BYTE1_MSB:`BYTE1_LSB] <= writedata_i[`BYTE1_MSB:`BYTE1_LSB];
			end
		end
	end

	// Reserved upper bits are not stored, so they always read back as zero
	always @(posedge clock_i) begin
		if (rst_i) begin
			ps_share <= `RST_PS_SHARE;
		end else if (wr_ok && sel_mix && byteenable_i[0]) begin
			ps_share <= writedata_i[`SHARE_W-1:0];
		end
	end

	// Control is reachable in any state; it is how power-up is entered
	always @(posedge clock_i) begin
		if (rst_i) begin
			control <= `RST_CONTROL;
		end else if (wr_ok && sel_ctl && byteenable_i[0]) begin
			control <= writedata_i[`CTL_W-1:0];
		end
	end

	// Busy count after any property access, then clear-to-send again
	// Count reloads on every property access, even one refused for power state
	// A host that ignores clear-to-send is not stopped; its access is served
	always @* begin
		next_cts     = cts;
		next_cts_cnt = cts_cnt;
		if (accept && is_prop) begin
			next_cts     = 1'b0;
			next_cts_cnt = CTS_LOAD;
		end else if (!cts) begin
			if (cts_cnt <= CTS_ONE) begin
				next_cts = 1'b1;
			end
			next_cts_cnt = cts_cnt - CTS_ONE;
		end
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			cts     <= 1'b1;
			cts_cnt <= {`CTS_CNT_W{1'b0}};
		end else begin
			cts     <= next_cts;
			cts_cnt <= next_cts_cnt;
		end
	end

	// Phase walks 0..7 once per slot, so any eight slots give the exact share
	// PS slots out of every eight; code 7 is illegal and treated as full
	always @* begin
		case (ps_share)
			3'h1: ps_slots = 4'h1;
			3'h2: ps_slots = 4'h2;
			3'h3: ps_slots = 4'h4;
			3'h4: ps_slots = 4'h6;
			3'h5: ps_slots = 4'h7;
			default: ps_slots = 4'h8;
		endcase
		if (ps_share == `SHARE_BUF_EMPTY) begin
			pick_ps = ~buf_any;
		end else begin
			pick_ps = ~buf_any | ({1'b0, phase} < ps_slots);
		end
	end

	// Last flags move on once a fetch is made, so they are taken with the slot
	wire                        take_ps    = slot_tick_i & pick_ps;
	wire                        want_buf   = slot_tick_i & ~pick_ps;
	wire                        take_queue = want_buf & queue_avail_i;
	wire                        take_ring  = want_buf & ~queue_avail_i & ring_avail_i;

	// One group per slot; the FIFO is served before the circular buffer
	always @(posedge clock_i) begin
		if (rst_i) begin
			phase       <= {`PHASE_W{1'b0}};
			ps_start    <= 1'b0;
			ring_fetch  <= 1'b0;
			queue_fetch <= 1'b0;
			ring_wrap   <= 1'b0;
			queue_empty <= 1'b0;
		end else begin
			ps_start    <= take_ps;
			queue_fetch <= take_queue;
			ring_fetch  <= take_ring;
			queue_empty <= take_queue & queue_last_i;
			ring_wrap   <= take_ring & ring_last_i;
			if (slot_tick_i) begin
				phase <= phase + PHASE_STEP;
			end
		end
	end

	// Each pulse becomes one sticky status bit on the next edge
	assign events[`EV_PS_SENT]     = ps_start;
	assign events[`EV_RING_SENT]   = ring_fetch;
	assign events[`EV_QUEUE_SENT]  = queue_fetch;
	assign events[`EV_RING_WRAP]   = ring_wrap;
	assign events[`EV_QUEUE_EMPTY] = queue_empty;
	// Clear-to-send event fires on the edge where the flag comes back
	assign events[`EV_CTS]         = ~cts & next_cts;

	// Enables only gate the interrupt; status keeps every event for polling
	// Reading status clears it; a new event in that cycle survives
	always @* begin
		next_status = status;
		if (rd_ok && sel_stat) begin
			next_status = {`EV_COUNT{1'b0}};
		end
		next_status = next_status | events;
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			status <= {`EV_COUNT{1'b0}};
		end else begin
			status <= next_status;
		end
	end

	// Level output: high while any unmasked sticky bit is set
	assign irq_o = |(status[`EN_COUNT-1:0] & irq_enables) |
	               (status[`EV_CTS] & control[`CTL_CTS_IRQ_EN]);

endmodule

/* File: rtl/rds_sched_consts.vh */
`ifndef RDS_SCHED_CONSTS_VH
`define RDS_SCHED_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_IRQ_ENABLES     16'h2C00
`define IDX_PROGRAM_IDENT   16'h2C01
`define IDX_PS_RATIO        16'h2C02
`define IDX_CONTROL         16'h2C10
`define IDX_EVENT_STATUS    16'h2C11
`define ADDR_BITS           18
`define IDX_LSB             2

// Reset values
`define RST_IRQ_ENABLES     5'h00
`define RST_PROGRAM_IDENT   16'h40A7
`define RST_PS_SHARE        3'h3
`define RST_CONTROL         2'h0

// Event bit positions, shared by enables and status; EV_CTS is in status only
`define EV_QUEUE_EMPTY      0
`define EV_RING_WRAP        1
`define EV_QUEUE_SENT       2
`define EV_RING_SENT        3
`define EV_PS_SENT          4
`define EV_CTS              5
`define EV_COUNT            6
`define EN_COUNT            5

// Control register fields
`define CTL_POWERED_UP      0
`define CTL_CTS_IRQ_EN      1
`define CTL_W               2

// Byte lanes of the identifier
`define BYTE0_LSB           0
`define BYTE0_MSB           7
`define BYTE1_LSB           8
`define BYTE1_MSB           15

// Mix code field
`define SHARE_W             3
`define SHARE_BUF_EMPTY     3'h0
`define SHARE_FULL          3'h6
`define SHARE_INVALID       3'h7
`define PHASE_W             3

// Clear-to-send busy time after a property access
`define CLK_PERIOD_NS       10
`define CTS_BUSY_NS         300
`define CTS_CNT_W           8

`endif

/* File: tb/rds_group_scheduler_irq_props.sv */
`timescale 1ns/100ps
`include "rds_sched_consts.vh"
module rds_sched_props (
	input wire                  clock_i,
	input wire                  rst_i,
	input wire [`ADDR_BITS-1:0] address_i,
	input wire                  read_i,
	input wire                  write_i,
	input wire                  waitrequest_o,
	input wire                  slot_tick_i,
	input wire                  ring_avail_i,
	input wire                  queue_avail_i,
	input wire                  ps_start_o,
	input wire                  ring_fetch_o,
	input wire                  queue_fetch_o,
	input wire [15:0]           block_a_ident_o,
	input wire [15:0]           block_c_ident_o,
	input wire                  cts_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	wire [15:0] idx  = address_i[17:2];
	wire        prop = write_i && !waitrequest_o && idx >= 16'h2C00 && idx <= 16'h2C02;
	wire [2:0]  outs = {ps_start_o, ring_fetch_o, queue_fetch_o};
	chk_one_source: assert property ($onehot0(outs))
		else $error("two group sources at once");
	chk_no_slot: assert property (!slot_tick_i |=> outs == 3'h0)
		else $error("group without slot");
	chk_ps_empty: assert property (slot_tick_i && !ring_avail_i && !queue_avail_i |=> ps_start_o)
		else $error("no ps group with empty buffers");
	chk_queue_need: assert property (slot_tick_i && !queue_avail_i |=> !queue_fetch_o)
		else $error("fetch from empty queue");
	chk_ring_order: assert property (slot_tick_i && (queue_avail_i || !ring_avail_i) |=> !ring_fetch_o)
		else $error("ring fetch not allowed");
	chk_ident_pair: assert property (block_a_ident_o == block_c_ident_o)
		else $error("block idents differ");
	chk_wait_one: assert property ((read_i || write_i) && !$past(read_i || write_i)
		|-> waitrequest_o ##1 !waitrequest_o)
		else $error("bus answer timing");
	chk_cts_busy: assert property (prop |=> !cts_o ##[1:64] cts_o)
		else $error("clear to send timing");
	cover property (slot_tick_i && !ring_avail_i && !queue_avail_i ##1 ps_start_o);
	cover property (queue_fetch_o);
	cover property (ring_fetch_o);
	cover property (prop ##1 !cts_o);
endmodule
bind rds_group_scheduler_irq rds_sched_props i_props (.clock_i, .rst_i, .address_i, .read_i,
	.write_i, .waitrequest_o, .slot_tick_i, .ring_avail_i, .queue_avail_i, .ps_start_o,
	.ring_fetch_o, .queue_fetch_o, .block_a_ident_o, .block_c_ident_o, .cts_o);

/* File: tb/rds_host_model.sv */
`timescale 1ns/100ps
module rds_host_model (
	input  wire         clock_i,
	input  wire         cts_i,
	input  wire         waitrequest_i,
	input  wire  [31:0] readdata_i,
	output logic [17:0] address_o,
	output logic        read_o,
	output logic        write_o,
	output logic [31:0] writedata_o,
	output logic [3:0]  byteenable_o
);
	initial {address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
	task acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		begin
			@(posedge clock_i);
			while (cts_i !== 1'b1) @(posedge clock_i);
			address_o <= {idx, 2'h0};
			write_o <= wr;
			read_o <= !wr;
			writedata_o <= wd;
			byteenable_o <= 4'hF;
			@(posedge clock_i);
			while (waitrequest_i !== 1'b0) @(posedge clock_i);
			rd = readdata_i;
			read_o <= 1'b0;
			write_o <= 1'b0;
			// Released data lines toggle so stale values never look valid
			writedata_o <= ~wd;
		end
	endtask
endmodule

/* File: tb/tb_rds_group_scheduler_irq.sv */
`timescale 1ns/100ps
`include "rds_sched_consts.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_rds_group_scheduler_irq;
	typedef struct {logic [15:0] idx; logic [31:0] wd; logic [31:0] ex;} row_t;
	logic        clock_i = 0, rst_i = 1, slot_tick_i = 0, ring_avail_i = 0, ring_last_i = 0;
	logic        queue_avail_i = 0, queue_last_i = 0;
	wire  [17:0] address_i;
	wire         read_i, write_i, waitrequest_o, irq_o, ps_start_o, ring_fetch_o;
	wire         queue_fetch_o, cts_o;
	wire  [31:0] writedata_i, readdata_o;
	wire  [3:0]  byteenable_i;
	wire  [15:0] block_a_ident_o, block_c_ident_o;
	int          n_mismatch = 0, cmp_count = 0, n_ps = 0;
	int          slots[6] = '{1, 2, 4, 6, 7, 8};
	logic [31:0] rd;
	logic [31:0] rv[3] = '{32'h0, 32'h40A7, 32'h3};
	row_t        rows[4] = '{'{16'h2C00, 32'h1F, 32'h1F}, '{16'h2C01, 32'h1234, 32'h1234},
		'{16'h2C02, 32'h6, 32'h6}, '{16'h2C20, 32'h55, 32'h0}};
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) if (ps_start_o) n_ps <= n_ps + 1;
	rds_group_scheduler_irq #(.CTS_BUSY_CYCLES(3)) i_dut (.clock_i, .rst_i, .address_i,
		.read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o, .irq_o,
		.slot_tick_i, .ring_avail_i, .ring_last_i, .queue_avail_i, .queue_last_i, .ps_start_o,
		.ring_fetch_o, .queue_fetch_o, .block_a_ident_o, .block_c_ident_o, .cts_o);
	rds_host_model i_host (.clock_i(clock_i), .cts_i(cts_o), .waitrequest_i(waitrequest_o),
		.readdata_i(readdata_o), .address_o(address_i), .read_o(read_i), .write_o(write_i),
		.writedata_o(writedata_i), .byteenable_o(byteenable_i));
	task summarize;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
			if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	// Clears status first so only this slot's events are seen
	task ev(input logic qa, ql, ra, rl, ie, input logic [2:0] pulse, input logic [31:0] st);
		begin
			i_host.acc(0, 16'h2C11, 0, rd);
			@(posedge clock_i);
			{queue_avail_i, queue_last_i, ring_avail_i, ring_last_i, slot_tick_i} <= {qa, ql, ra, rl, 1'b1};
			@(posedge clock_i);
			slot_tick_i <= 0;
			#1 `CHK({ps_start_o, ring_fetch_o, queue_fetch_o}, pulse)
			@(posedge clock_i);
			#1 `CHK(irq_o, ie)
			i_host.acc(0, 16'h2C11, 0, rd);
			#1 `CHK(rd, st)
			`CHK(irq_o, 1'b0)
		end
	endtask
	initial begin
		#200000;
		n_mismatch++;
		summarize;
	end
	initial begin
		repeat (10) @(posedge clock_i);
		rst_i <= 0;
		#1 `CHK(block_a_ident_o, 16'h40A7)
		`CHK(cts_o, 1'b1)
		i_host.acc(1, 16'h2C01, 32'hBEEF, rd);
		i_host.acc(0, 16'h2C01, 0, rd);
		`CHK(rd, 32'h0)
		i_host.acc(1, 16'h2C10, 32'h1, rd);
		for (int i = 0; i < 3; i++) begin
			i_host.acc(0, 16'h2C00 + i, 0, rd);
			`CHK(rd, rv[i])
		end
		foreach (rows[i]) begin
			i_host.acc(1, rows[i].idx, rows[i].wd, rd);
			i_host.acc(0, rows[i].idx, 0, rd);
			`CHK(rd, rows[i].ex)
		end
		`CHK(block_c_ident_o, 16'h1234)
		i_host.acc(1, 16'h2C02, 0, rd);
		ev(1, 1, 0, 0, 1, 3'h1, 32'h05);
		ev(0, 0, 1, 1, 1, 3'h2, 32'h0A);
		ev(0, 0, 0, 0, 1, 3'h4, 32'h10);
		i_host.acc(1, 16'h2C00, 0, rd);
		ev(1, 1, 0, 0, 0, 3'h1, 32'h05);
		for (int c = 1; c < 7; c++) begin
			i_host.acc(1, 16'h2C02, c, rd);
			n_ps = 0;
			{queue_avail_i, queue_last_i, slot_tick_i} <= 3'h5;
			repeat (8) @(posedge clock_i);
			slot_tick_i <= 0;
			repeat (2) @(posedge clock_i);
			#1 `CHK(n_ps, slots[c-1])
		end
		// Reset in mid-run brings every setting back
		i_host.acc(1, 16'h2C00, 32'h1F, rd);
		@(posedge clock_i);
		rst_i <= 1;
		repeat (2) @(posedge clock_i);
		rst_i <= 0;
		#1 `CHK(block_a_ident_o, 16'h40A7)
		`CHK({cts_o, irq_o}, 2'h2)
		i_host.acc(1, 16'h2C10, 32'h1, rd);
		i_host.acc(0, 16'h2C00, 0, rd);
		`CHK(rd, 32'h0)
		i_host.acc(0, 16'h2C02, 0, rd);
		`CHK(rd, 32'h3)
		// Clear-to-send event with its interrupt enabled
		i_host.acc(1, 16'h2C10, 32'h3, rd);
		i_host.acc(0, 16'h2C11, 0, rd);
		`CHK(rd, 32'h20)
		#1 `CHK(irq_o, 1'b0)
		i_host.acc(1, 16'h2C01, 32'hA5C3, rd);
		repeat (5) @(posedge clock_i);
		#1 `CHK(irq_o, 1'b1)
		`CHK(block_a_ident_o, 16'hA5C3)
		summarize;
	end
endmodule
